// >>> logic/rpic_clk_div.sv
// Purpose: Divide-by-N rate generator giving a tick pulse and a near-square level
// Assumes: div_in of 0 or run_in low stops the output low
// Notes:   Divide by 1 cannot toggle at the clock rate from a flop; the level then stays high
`timescale 1ns/100ps
module rpic_clk_div #(
  parameter int W = 4
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] div_in,
  output logic              tick_out,
  output logic              level_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  wire logic active  = run_in && (div_in != '0);
  // A shrinking divisor must not strand the count above the new end
  wire logic last    = active && (cnt_q >= div_in - W'(1));
  assign cnt_d       = (!active || last) ? '0 : cnt_q + W'(1);
  wire logic level_d = active && ((div_in == W'(1)) || (cnt_d < (div_in >> 1)));

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cnt_q     <= '0;
      tick_out  <= 1'b0;
      level_out <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      tick_out  <= last;
      level_out <= level_d;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  div_stop_a: assert property (!active |=> !tick_out && !level_out)
    else $error("divider ticked while stopped");
  div_range_a: assert property (active && $stable(div_in) |=> cnt_q < $past(div_in))
    else $error("divider count out of range");

endmodule : rpic_clk_div

// >>> logic/rpic_flag_bank.sv
// Purpose: Sticky event flags, cleared by writing ones
// Assumes: set_in and clr_in are single-cycle strobes
// Notes:   A set in the clearing cycle survives so no event is lost
`timescale 1ns/100ps
module rpic_flag_bank #(
  parameter int             W    = 8,
  parameter logic [W-1:0]   USED = '1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic [W-1:0]      flags_out
);

  wire logic [W-1:0] flags_d = ((flags_out & ~clr_in) | set_in) & USED;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= flags_d;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  set_wins_a: assert property ((set_in & USED) != '0 |=>
      (flags_out & $past(set_in) & USED) == ($past(set_in) & USED))
    else $error("flag set was lost");
  flag_hold_a: assert property (clr_in == '0 |=>
      (flags_out & $past(flags_out)) == $past(flags_out))
    else $error("flag dropped without a clear");
  unused_zero_a: assert property ((flags_out & ~USED) == '0)
    else $error("unused flag bit set");

endmodule : rpic_flag_bank

// >>> logic/rpic_pkg.sv
// Purpose: Shared offsets, field layouts, reset values and carriers of the radio register bank
// Assumes: 10-bit register addresses, 8-bit data
// Notes:   Masks mark the implemented bits of each writable register; the rest read as zero
package rpic_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [9:0] OFS_POWER_OFF    = 10'h322;
  localparam logic [9:0] OFS_RX_EN        = 10'h324;
  localparam logic [9:0] OFS_MON_EN       = 10'h325;
  localparam logic [9:0] OFS_CONV_UPPER   = 10'h327;
  localparam logic [9:0] OFS_CONV_LOWER   = 10'h328;
  localparam logic [9:0] OFS_ALARM_LEVEL  = 10'h32d;
  localparam logic [9:0] OFS_HOST_CLK_DIV = 10'h32e;
  localparam logic [9:0] OFS_GAIN_DIV     = 10'h32f;
  localparam logic [9:0] OFS_PKT_FLAGS    = 10'h336;
  localparam logic [9:0] OFS_SYS_FLAGS    = 10'h337;
  localparam logic [9:0] OFS_TUNE_EN      = 10'h338;
  localparam logic [9:0] OFS_TUNE_STATUS  = 10'h339;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_POWER_OFF   = 8'h01;
  localparam logic [7:0] MASK_RX_EN       = 8'h1f;
  localparam logic [7:0] MASK_MON_EN      = 8'h03;
  localparam logic [7:0] MASK_ALARM_LEVEL = 8'h1f;
  localparam logic [7:0] MASK_HOST_DIV    = 8'h0f;
  localparam logic [7:0] MASK_GAIN_DIV    = 8'hff;
  localparam logic [7:0] MASK_PKT_FLAGS   = 8'hff;
  localparam logic [7:0] MASK_SYS_FLAGS   = 8'hd3;
  localparam logic [7:0] MASK_TUNE        = 8'h03;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_HOST_DIV     = 8'h04;
  localparam logic [7:0] RST_GAIN_DIV     = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and scale figures
  // ----------------------------------------------------------------
  localparam int BIT_TEMP_WATCH    = 1;
  localparam int BIT_SUPPLY_WATCH  = 0;
  localparam int BIT_POWER_OFF_REQ = 0;
  localparam int BIT_SYNTH_TUNE    = 1;
  localparam int BIT_FILTER_TUNE   = 0;
  localparam int PKT_WAKE_COUNT    = 7;
  localparam int PKT_SMART_WAKE    = 6;
  localparam int PKT_CIPHER_DONE   = 5;
  localparam int PKT_TX_DONE       = 4;
  localparam int PKT_ADDR_MATCH    = 3;
  localparam int PKT_CRC_OK        = 2;
  localparam int PKT_SYNC_FOUND    = 1;
  localparam int PKT_PREAMBLE      = 0;
  localparam int SYS_SUPPLY_LOW    = 7;
  localparam int SYS_CMD_READY     = 6;
  localparam int SYS_WAKE_TIMER    = 4;
  localparam int SYS_SERIAL_READY  = 1;
  localparam int SYS_CMD_FINISHED  = 0;
  localparam logic [11:0] TRIP_BASE_MV  = 12'h6a4;
  localparam logic [11:0] TRIP_STEP_MV  = 12'h03e;
  localparam logic [11:0] GAIN_PRESCALE = 12'h010;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rpic_bus_req_type;

  typedef struct packed {
    logic converter_on;
    logic signal_strength_on;
    logic if_filter_on;
    logic mixer_on;
    logic low_noise_amp_on;
  } rpic_rx_en_type;

  typedef struct packed {
    logic cipher_done;
    logic tx_done;
    logic addr_match;
    logic crc_ok;
    logic sync_found;
    logic preamble_found;
  } rpic_pkt_evt_type;

  typedef struct packed {
    logic cmd_ready;
    logic wake_timer_expired;
    logic serial_ready;
    logic cmd_finished;
  } rpic_sys_evt_type;

endpackage : rpic_pkg

// >>> logic/rpic_regs.sv
// Purpose: Power, monitor, divider, event flag and tuning registers of the radio core
// Assumes: Inputs synchronous to ref_clk_in; one access per cycle on the register port
// Notes:   Reads answer one cycle after the strobe; unmapped reads return zero
`timescale 1ns/100ps
module rpic_regs (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_b_in,
  input  wire rpic_pkg::rpic_bus_req_type bus_req_in,
  output logic [7:0]                     rd_data_out,
  output logic                           rd_valid_out,
  input  wire logic                      chip_sel_in,
  input  wire logic [7:0]                adc_result_in,
  input  wire logic                      supply_low_in,
  input  wire logic                      fsk_mode_in,
  input  wire logic                      packet_mode_in,
  input  wire logic                      cipher_loaded_in,
  input  wire logic                      smart_wake_active_in,
  input  wire logic [7:0]                signal_level_in,
  input  wire logic [7:0]                smart_wake_level_limit_in,
  input  wire logic [15:0]               wake_count_in,
  input  wire logic [15:0]               wake_count_limit_in,
  input  wire rpic_pkg::rpic_pkt_evt_type pkt_evt_in,
  input  wire rpic_pkg::rpic_sys_evt_type sys_evt_in,
  input  wire logic                      synthesizer_tune_done_in,
  input  wire logic                      baseband_filter_tune_done_in,
  output logic                           power_off_start_out,
  output rpic_pkg::rpic_rx_en_type       rx_enables_out,
  output logic                           temperature_watch_on_out,
  output logic                           supply_watch_on_out,
  output logic [11:0]                    supply_trip_mv_out,
  output logic                           clock_output_pin_out,
  output logic                           gain_loop_tick_out,
  output logic                           synthesizer_tune_enable_out,
  output logic                           baseband_filter_tune_enable_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic [9:0] addr  = bus_req_in.addr;
  wire logic [7:0] wdata = bus_req_in.wdata;
  wire logic       wr    = bus_req_in.wr;

  wire logic wr_power = wr && hit(addr, rpic_pkg::OFS_POWER_OFF);
  wire logic wr_rx    = wr && hit(addr, rpic_pkg::OFS_RX_EN);
  wire logic wr_mon   = wr && hit(addr, rpic_pkg::OFS_MON_EN);
  wire logic wr_alarm = wr && hit(addr, rpic_pkg::OFS_ALARM_LEVEL);
  wire logic wr_hdiv  = wr && hit(addr, rpic_pkg::OFS_HOST_CLK_DIV);
  wire logic wr_gdiv  = wr && hit(addr, rpic_pkg::OFS_GAIN_DIV);
  wire logic wr_pkt   = wr && hit(addr, rpic_pkg::OFS_PKT_FLAGS);
  wire logic wr_sys   = wr && hit(addr, rpic_pkg::OFS_SYS_FLAGS);
  wire logic wr_tune  = wr && hit(addr, rpic_pkg::OFS_TUNE_EN);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] power_q;
  logic [7:0] rx_q;
  logic [7:0] mon_q;
  logic [7:0] alarm_q;
  logic [7:0] hdiv_q;
  logic [7:0] gdiv_q;
  logic [7:0] tune_q;
  logic [7:0] status_q;

  wire logic [7:0] power_d = wr_power ? (wdata & rpic_pkg::MASK_POWER_OFF)   : power_q;
  wire logic [7:0] rx_d    = wr_rx    ? (wdata & rpic_pkg::MASK_RX_EN)       : rx_q;
  wire logic [7:0] mon_d   = wr_mon   ? (wdata & rpic_pkg::MASK_MON_EN)      : mon_q;
  wire logic [7:0] alarm_d = wr_alarm ? (wdata & rpic_pkg::MASK_ALARM_LEVEL) : alarm_q;
  wire logic [7:0] hdiv_d  = wr_hdiv  ? (wdata & rpic_pkg::MASK_HOST_DIV)    : hdiv_q;
  wire logic [7:0] gdiv_d  = wr_gdiv  ? (wdata & rpic_pkg::MASK_GAIN_DIV)    : gdiv_q;
  wire logic [7:0] tune_d  = wr_tune  ? (wdata & rpic_pkg::MASK_TUNE)        : tune_q;
  wire logic [7:0] status_d = {6'h00, synthesizer_tune_done_in, baseband_filter_tune_done_in};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      power_q  <= rpic_pkg::RST_ZERO;
      rx_q     <= rpic_pkg::RST_ZERO;
      mon_q    <= rpic_pkg::RST_ZERO;
      alarm_q  <= rpic_pkg::RST_ZERO;
      hdiv_q   <= rpic_pkg::RST_HOST_DIV;
      gdiv_q   <= rpic_pkg::RST_GAIN_DIV;
      tune_q   <= rpic_pkg::RST_ZERO;
      status_q <= rpic_pkg::RST_ZERO;
    end else begin
      power_q  <= power_d;
      rx_q     <= rx_d;
      mon_q    <= mon_d;
      alarm_q  <= alarm_d;
      hdiv_q   <= hdiv_d;
      gdiv_q   <= gdiv_d;
      tune_q   <= tune_d;
      status_q <= status_d;
    end
  end

  assign rx_enables_out                  = rpic_pkg::rpic_rx_en_type'(rx_q[4:0]);
  assign temperature_watch_on_out        = mon_q[rpic_pkg::BIT_TEMP_WATCH];
  assign supply_watch_on_out             = mon_q[rpic_pkg::BIT_SUPPLY_WATCH];
  assign synthesizer_tune_enable_out     = tune_q[rpic_pkg::BIT_SYNTH_TUNE];
  assign baseband_filter_tune_enable_out = tune_q[rpic_pkg::BIT_FILTER_TUNE];

  // ----------------------------------------------------------------
  // Shutdown and supply trip level
  // ----------------------------------------------------------------
  // shutdown needs chip select high
  wire logic power_off_d = power_q[rpic_pkg::BIT_POWER_OFF_REQ] && chip_sel_in;
  // trip level in millivolts for the comparator reference
  wire logic [11:0] trip_mv_d = rpic_pkg::TRIP_BASE_MV +
                                12'(alarm_q[4:0]) * rpic_pkg::TRIP_STEP_MV;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      power_off_start_out <= 1'b0;
      supply_trip_mv_out  <= rpic_pkg::TRIP_BASE_MV;
    end else begin
      power_off_start_out <= power_off_d;
      supply_trip_mv_out  <= trip_mv_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  // host clock output divider
  rpic_clk_div #(.W(4)) u_host_clk (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .run_in     (1'b1),
    .div_in     (hdiv_q[3:0]),
    .tick_out   (),
    .level_out  (clock_output_pin_out)
  );

  // gain loop runs only in FSK modes, sixteen-fold prescale
  wire logic [11:0] gain_div = 12'(gdiv_q) * rpic_pkg::GAIN_PRESCALE;

  rpic_clk_div #(.W(12)) u_gain_clk (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .run_in     (fsk_mode_in),
    .div_in     (gain_div),
    .tick_out   (gain_loop_tick_out),
    .level_out  ()
  );

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic [7:0] pkt_set;
  logic [7:0] sys_set;
  logic [7:0] pkt_flags;
  logic [7:0] sys_flags;

  assign pkt_set[rpic_pkg::PKT_WAKE_COUNT]  = (wake_count_in == wake_count_limit_in);
  assign pkt_set[rpic_pkg::PKT_SMART_WAKE]  = smart_wake_active_in &&
                                              (signal_level_in > smart_wake_level_limit_in);
  assign pkt_set[rpic_pkg::PKT_CIPHER_DONE] = pkt_evt_in.cipher_done && cipher_loaded_in;
  assign pkt_set[rpic_pkg::PKT_TX_DONE]     = pkt_evt_in.tx_done && packet_mode_in;
  assign pkt_set[rpic_pkg::PKT_ADDR_MATCH]  = pkt_evt_in.addr_match && packet_mode_in;
  assign pkt_set[rpic_pkg::PKT_CRC_OK]      = pkt_evt_in.crc_ok && packet_mode_in;
  assign pkt_set[rpic_pkg::PKT_SYNC_FOUND]  = pkt_evt_in.sync_found;
  assign pkt_set[rpic_pkg::PKT_PREAMBLE]    = pkt_evt_in.preamble_found;

  assign sys_set[rpic_pkg::SYS_SUPPLY_LOW]   = supply_low_in && supply_watch_on_out;
  assign sys_set[rpic_pkg::SYS_CMD_READY]    = sys_evt_in.cmd_ready;
  // wake timer expired, spare bits idle
  assign sys_set[rpic_pkg::SYS_WAKE_TIMER]   = sys_evt_in.wake_timer_expired;
  assign sys_set[5]                          = 1'b0;
  assign sys_set[3:2]                        = 2'h0;
  assign sys_set[rpic_pkg::SYS_SERIAL_READY] = sys_evt_in.serial_ready;
  assign sys_set[rpic_pkg::SYS_CMD_FINISHED] = sys_evt_in.cmd_finished;

  rpic_flag_bank #(.W(8), .USED(rpic_pkg::MASK_PKT_FLAGS)) u_pkt_flags (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .set_in     (pkt_set),
    .clr_in     (wr_pkt ? wdata : 8'h00),
    .flags_out  (pkt_flags)
  );

  rpic_flag_bank #(.W(8), .USED(rpic_pkg::MASK_SYS_FLAGS)) u_sys_flags (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .set_in     (sys_set),
    .clr_in     (wr_sys ? wdata : 8'h00),
    .flags_out  (sys_flags)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // converter result split
  wire logic [7:0] conv_upper = {2'h0, adc_result_in[7:2]};
  wire logic [7:0] conv_lower = {adc_result_in[1:0], 6'h00};

  wire logic [7:0] rd_mux =
    hit(addr, rpic_pkg::OFS_POWER_OFF)    ? power_q    :
    hit(addr, rpic_pkg::OFS_RX_EN)        ? rx_q       :
    hit(addr, rpic_pkg::OFS_MON_EN)       ? mon_q      :
    hit(addr, rpic_pkg::OFS_CONV_UPPER)   ? conv_upper :
    hit(addr, rpic_pkg::OFS_CONV_LOWER)   ? conv_lower :
    hit(addr, rpic_pkg::OFS_ALARM_LEVEL)  ? alarm_q    :
    hit(addr, rpic_pkg::OFS_HOST_CLK_DIV) ? hdiv_q     :
    hit(addr, rpic_pkg::OFS_GAIN_DIV)     ? gdiv_q     :
    hit(addr, rpic_pkg::OFS_PKT_FLAGS)    ? pkt_flags  :
    hit(addr, rpic_pkg::OFS_SYS_FLAGS)    ? sys_flags  :
    hit(addr, rpic_pkg::OFS_TUNE_EN)      ? tune_q     :
    hit(addr, rpic_pkg::OFS_TUNE_STATUS)  ? status_q   : 8'h00;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_data_out  <= bus_req_in.rd ? rd_mux : rd_data_out;
      rd_valid_out <= bus_req_in.rd;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  shutdown_gate_a: assert property (power_off_start_out |->
      $past(power_q[0]) && $past(chip_sel_in))
    else $error("shutdown started without request and chip select");
  rx_enable_a: assert property (wr_rx |=> rx_enables_out == $past(wdata[4:0]))
    else $error("receive enables did not follow write");
  monitor_enable_a: assert property (wr_mon |=>
      temperature_watch_on_out == $past(wdata[1]) && supply_watch_on_out == $past(wdata[0]))
    else $error("monitor enables did not follow write");
  conv_split_a: assert property (bus_req_in.rd && hit(addr, rpic_pkg::OFS_CONV_LOWER) |=>
      rd_valid_out && rd_data_out == {$past(adc_result_in[1:0]), 6'h00})
    else $error("converter low bits misplaced");
  trip_level_a: assert property (wr_alarm ##1 !wr_alarm |=>
      supply_trip_mv_out == rpic_pkg::TRIP_BASE_MV + 12'(alarm_q[4:0]) * rpic_pkg::TRIP_STEP_MV)
    else $error("trip level wrong");
  supply_alarm_a: assert property (supply_low_in && supply_watch_on_out |=> sys_flags[7])
    else $error("supply alarm flag not set");
  wake_count_a: assert property (wake_count_in == wake_count_limit_in |=> pkt_flags[7])
    else $error("wake count flag not set");
  tx_mode_gate_a: assert property (!pkt_flags[4] && !packet_mode_in && !wr_pkt |=>
      !pkt_flags[4])
    else $error("transmit flag set outside packet mode");
  tune_enable_a: assert property (wr_tune |=>
      synthesizer_tune_enable_out == $past(wdata[1]) &&
      baseband_filter_tune_enable_out == $past(wdata[0]))
    else $error("tuning enables did not follow write");
  tune_status_a: assert property (bus_req_in.rd && hit(addr, rpic_pkg::OFS_TUNE_STATUS) |=>
      rd_data_out[1] == $past(synthesizer_tune_done_in, 2))
    else $error("synthesizer status read wrong");
  filter_status_a: assert property (bus_req_in.rd &&
      hit(addr, rpic_pkg::OFS_TUNE_STATUS) |=>
      rd_data_out[0] == $past(baseband_filter_tune_done_in, 2))
    else $error("filter status read wrong");
  reserved_read_a: assert property (bus_req_in.rd && hit(addr, rpic_pkg::OFS_RX_EN) |=>
      rd_data_out[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  host_div_reset_a: assert property ($rose(rst_b_in) |-> hdiv_q == 8'h04 && gdiv_q == 8'h28)
    else $error("divider reset values wrong");

  // Event capture, one cycle after the qualified event
  smart_wake_a: assert property (smart_wake_active_in &&
      signal_level_in > smart_wake_level_limit_in |=> pkt_flags[6])
    else $error("smart wake flag not set");
  cipher_gate_a: assert property (!pkt_flags[5] && !cipher_loaded_in && !wr_pkt |=>
      !pkt_flags[5])
    else $error("cipher flag set without firmware");
  addr_gate_a: assert property (!pkt_flags[3] && !packet_mode_in && !wr_pkt |=>
      !pkt_flags[3])
    else $error("address flag set outside packet mode");
  crc_gate_a: assert property (!pkt_flags[2] && !packet_mode_in && !wr_pkt |=>
      !pkt_flags[2])
    else $error("checksum flag set outside packet mode");
  sync_flag_a: assert property (pkt_evt_in.sync_found |=> pkt_flags[1])
    else $error("sync flag not set");
  preamble_flag_a: assert property (pkt_evt_in.preamble_found |=> pkt_flags[0])
    else $error("preamble flag not set");
  cmd_ready_a: assert property (sys_evt_in.cmd_ready |=> sys_flags[6])
    else $error("command ready flag not set");
  wake_timer_a: assert property (sys_evt_in.wake_timer_expired |=> sys_flags[4])
    else $error("wake timer flag not set");
  serial_ready_a: assert property (sys_evt_in.serial_ready |=> sys_flags[1])
    else $error("serial ready flag not set");
  cmd_done_a: assert property (sys_evt_in.cmd_finished |=> sys_flags[0])
    else $error("command finished flag not set");

  shutdown_c: cover property (power_off_start_out);
  flag_clear_c: cover property (wr_pkt && pkt_flags != 8'h00 ##1 pkt_flags == 8'h00);
  set_clear_race_c: cover property (wr_sys && wdata[0] && sys_set[0]);
  gain_tick_c: cover property (gain_loop_tick_out);
  pkt_gate_c: cover property (packet_mode_in && pkt_evt_in.crc_ok);

endmodule : rpic_regs

// >>> tb/radio_power_irq_cal_regs_tb_top.sv
// Purpose: Self-checking bench of the radio register bank
// Assumes: Host model drives the register port
// Notes:   Fixed-seed random data; flag events placed by hand
`timescale 1ns/100ps
module radio_power_irq_cal_regs_tb_top;
  logic ref_clk_in = 0, rst_b_in = 0, cs = 0, low = 0, pm = 0;
  logic rv, poff, tw, sw, ste, bte, cko, gtk;
  logic [7:0] adc = 0, lvl = 0, misc = 0, rdat;
  logic [7:0] wd [11];
  logic [11:0] trip, hi = 0, tk = 0;
  logic [15:0] wcnt = 0;
  rpic_pkg::rpic_pkt_evt_type pev = '0;
  rpic_pkg::rpic_sys_evt_type sev = '0;
  rpic_pkg::rpic_bus_req_type req;
  rpic_pkg::rpic_rx_en_type rxe;
  int err_count, n_checks, cyc;
  integer seed = 32'h8235;
  logic [9:0] adr [11] = '{10'h322, 10'h324, 10'h325, 10'h327, 10'h328, 10'h32d,
                           10'h32e, 10'h32f, 10'h336, 10'h337, 10'h338};
  logic [7:0] msk [11] = '{8'h01, 8'h1f, 8'h03, 8'h00, 8'h00, 8'h1f, 8'h0f, 8'hff,
                           8'h00, 8'h00, 8'h03};
  rpic_host_model host (.ref_clk_in(ref_clk_in), .bus_req_out(req));
  rpic_regs dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus_req_in(req),
    .rd_data_out(rdat), .rd_valid_out(rv), .chip_sel_in(cs), .adc_result_in(adc),
    .supply_low_in(low), .fsk_mode_in(misc[0]), .packet_mode_in(pm),
    .cipher_loaded_in(misc[1]), .smart_wake_active_in(misc[2]), .signal_level_in(lvl),
    .smart_wake_level_limit_in(8'h80), .wake_count_in(wcnt),
    .wake_count_limit_in(16'h0100), .pkt_evt_in(pev), .sys_evt_in(sev),
    .synthesizer_tune_done_in(misc[3]), .baseband_filter_tune_done_in(misc[4]),
    .power_off_start_out(poff), .rx_enables_out(rxe), .temperature_watch_on_out(tw),
    .supply_watch_on_out(sw), .supply_trip_mv_out(trip), .clock_output_pin_out(cko),
    .gain_loop_tick_out(gtk), .synthesizer_tune_enable_out(ste),
    .baseband_filter_tune_enable_out(bte));
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00);
    #1;
    chk("rd_valid", 12'h001, 12'(rv));
    chk("rd_data", 12'(e), 12'(rdat));
  endtask : rd
  function automatic logic [7:0] exp_of(int i, logic [7:0] d);
    if (i == 3) return {2'b00, adc[7:2]};
    if (i == 4) return {adc[1:0], 6'h00};
    return d & msk[i];
  endfunction : exp_of
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    // Default divisor 4: two periods, half of them high
    repeat (8) begin
      @(posedge ref_clk_in);
      #1 hi = hi + 12'(cko);
    end
    chk("clk_out_high", 12'd4, hi);
    for (int i = 0; i < 11; i++) rd(adr[i], i == 6 ? 8'h04 : i == 7 ? 8'h28 : 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_in);
      adc <= 8'($random(seed));
      cs <= 1'(k);
      misc <= 8'($random(seed)) & 8'h1b;
      for (int i = 0; i < 11; i++) begin
        wd[i] = 8'($random(seed));
        host.access(1'b1, adr[i], wd[i]);
        rd(adr[i], exp_of(i, wd[i]));
      end
      host.access(1'b1, 10'h323, 8'hff);
      rd(10'h323, 8'h00);
      rd(10'h339, 8'({misc[3], misc[4]}));
      chk("power_off", 12'(wd[0][0] & cs), 12'(poff));
      chk("rx_en", 12'(wd[1][4:0]), 12'(rxe));
      chk("watch", 12'(wd[2][1:0]), 12'({tw, sw}));
      chk("trip_mv", 12'd1700 + 12'd62 * 12'(wd[5][4:0]), trip);
      chk("tune_en", 12'(wd[10][1:0]), 12'({ste, bte}));
    end
    host.access(1'b1, 10'h322, 8'h01);
    cs <= 1'b1;
    @(posedge ref_clk_in);
    #1 chk("power_off_set", 12'h001, 12'(poff));
    @(posedge ref_clk_in);
    cs <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("power_off_cs", 12'h000, 12'(poff));
    $display("test registers done");
    host.access(1'b1, 10'h325, 8'h01);
    // Packet mode off: only ungated events land
    @(posedge ref_clk_in);
    {misc, sev, pev, lvl, wcnt, low} <= {8'h04, 4'h8, 6'h1f, 8'h81, 16'h0100, 1'b1};
    @(posedge ref_clk_in);
    {sev, pev, lvl, wcnt, low} <= '0;
    rd(10'h336, 8'hc3);
    rd(10'h337, 8'hc0);
    host.access(1'b1, 10'h336, 8'hff);
    host.access(1'b1, 10'h337, 8'hc0);
    rd(10'h337, 8'h00);
    @(posedge ref_clk_in);
    {misc, pm, pev} <= {8'h02, 1'b1, 6'h3f};
    @(posedge ref_clk_in);
    pev <= '0;
    rd(10'h336, 8'h3f);
    // Event still present in the clearing cycle must survive
    @(posedge ref_clk_in);
    sev <= 4'h1;
    host.access(1'b1, 10'h337, 8'h01);
    sev <= '0;
    rd(10'h337, 8'h01);
    host.access(1'b1, 10'h32f, 8'h01);
    misc <= 8'h01;
    repeat (32) begin
      @(posedge ref_clk_in);
      #1 tk = tk + 12'(gtk);
    end
    chk("gain_ticks", 12'd2, tk);
    $display("test flags done");
    complete_run();
  end
endmodule : radio_power_irq_cal_regs_tb_top

// >>> tb/rpic_host_model.sv
// Purpose: Host side of the register port
// Assumes: Requests launch just after a rising edge
// Notes:   Idle bus shows inverted address and data
`timescale 1ns/100ps
module rpic_host_model (
  input  wire logic                  ref_clk_in,
  output rpic_pkg::rpic_bus_req_type bus_req_out
);
  initial bus_req_out = '0;
  task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus_req_out <= '{w, !w, a, d};
    @(posedge ref_clk_in);
    bus_req_out <= '{1'b0, 1'b0, ~a, ~d};
  endtask : access
endmodule : rpic_host_model
